// ==== rtl/tsf_defs.svh ====
/*
  Bit positions, field codes and widths for the timer event status block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH

// Status register bit positions (bit 32 of the 32-bit word is index 31)
`define TSF_ARM_BIT 31
`define TSF_WIS_BIT 30
`define TSF_WRS_HI 29
`define TSF_WRS_LO 28
`define TSF_DEC_BIT 27
`define TSF_FIT_BIT 26
`define TSF_REG_W 32
// Reset-control codes
`define TSF_RC_NONE 2'h0
`define TSF_RC_CHECKSTOP 2'h1
`define TSF_RC_RESET 2'h2
// Time base and selector widths, and the selector value for the top time base bit
`define TSF_TB_W 64
`define TSF_SEL_W 6
`define TSF_SEL_MSB 6'h00

`endif

// ==== rtl/tsf_pkg.sv ====
/*
  Types shared by the timer event status block.
  Assumes tsf_defs.svh is reachable on the include path.
*/
`include "tsf_defs.svh"
package tsf_pkg;
  // Watchdog stage, reset-status, decrementer and fixed-interval fields
  typedef struct packed {
    logic next_timeout_arm;
    logic wdog_intr_status;
    logic [1:0] wdog_reset_status;
    logic dec_event_flag;
    logic fixed_interval_flag;
  } tsf_status_s;

  // Interrupt gates from control and machine state
  typedef struct packed {
    logic wdog_intr_enable;
    logic dec_intr_enable;
    logic fixed_interval_intr_enable;
    logic crit_intr_gate;
    logic ext_intr_gate;
  } tsf_gate_s;

  // Watchdog second time-out reaction state
  typedef enum logic [1:0] {
    TSF_WD_IDLE = 2'b00,
    TSF_WD_CHECKSTOP = 2'b01,
    TSF_WD_RESET = 2'b10
  } tsf_wd_e;
endpackage : tsf_pkg

// ==== rtl/tsf_edge.sv ====
/*
  Selects one time base bit and flags its rise from 0 to 1.
  Assumes the time base is synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tsf_defs.svh"
module tsf_edge
  import tsf_pkg::*;
#(
  parameter int TB_W = `TSF_TB_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Time base and selector
  input wire logic [TB_W-1:0] time_base,
  input wire logic [`TSF_SEL_W-1:0] bit_select,
  // Rise pulse
  output logic rise
);
  logic prev_ff;
  logic nxt_prev;
  logic cur;

  // Selector 0 picks the most significant time base bit
  always_comb begin
    cur = time_base[TB_W-1-int'(bit_select)];
    nxt_prev = cur;
    rise = cur & ~prev_ff;
  end

  // Last sampled bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= nxt_prev;
    end
  end
endmodule : tsf_edge
`default_nettype wire

// ==== rtl/tsf_status.sv ====
/*
  Timer event status register: watchdog two-stage time-out, decrementer and
  fixed-interval flags, write-one-to-clear access, interrupt requests.
  Assumes a synchronous time base, a decrementer event pulse, and core
  special-register read and write strobes, all on mclk.
*/
// Notes on behaviour
// (R1) Each clearable flag clears only where a one is written; a zero keeps it.
// (R2) A time-out with interrupt status 0 and arm 1 raises the exception and sets status.
// (R3) With arm 0 a time-out only sets the arm bit.
// (R4) With arm 1 and status already set, a time-out is the second time-out.
// (R5) Watchdog interrupt is requested when status, enable and critical gate are all 1.
// (R6) The reset-status field reports none, checkstop or reset output taken.
// (R7) The decrementer flag requests an interrupt when external gate and its enable are 1.
// (R8) The fixed-interval flag requests an interrupt when external gate and its enable are 1.
// (R9) The register reads whole and its write value is only a clear mask.
// (R10) Software clears interrupt status before reopening critical interrupts.
// (R11) Bits 38 to 63 are reserved and have no function.
// (R12) A watchdog time-out is a 0-to-1 rise of the selected time base bit.
// (R13) A second time-out acts per reset control: none, checkstop or reset output.
// (R14) A fixed-interval event is a 0-to-1 rise of its selected time base bit.
// (R15) A second time-out copies reset control into the reset-status field.
// (R16) Reserved bits read as zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "tsf_defs.svh"
module tsf_status
  import tsf_pkg::*;
#(
  parameter int TB_W = `TSF_TB_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timer sources
  input wire logic [TB_W-1:0] time_base,
  input wire logic dec_zero_event,
  // Timer control fields
  input wire logic [1:0] wdog_period,
  input wire logic [3:0] wdog_period_extension,
  input wire logic [1:0] interval_period_select,
  input wire logic [3:0] interval_period_extension,
  input wire logic [1:0] wdog_reset_control,
  // Interrupt gates
  input wire tsf_gate_s gates,
  // Special-register access
  input wire logic status_rd,
  input wire logic status_wr,
  input wire logic [`TSF_REG_W-1:0] status_wdata,
  output logic [`TSF_REG_W-1:0] status_rdata,
  // Interrupt requests and watchdog outputs
  output logic wdog_intr_req,
  output logic dec_intr_req,
  output logic fixed_interval_intr_req,
  output logic wdog_exception,
  output logic checkstop,
  output logic reset_out_n
);
  // --------------------------------------------------------------------
  // Time-out detection
  // --------------------------------------------------------------------
  logic wd_tick;
  logic fit_tick;

  // Watchdog period select: extension above period
  tsf_edge #(.TB_W(TB_W)) u_wd_edge (
    .mclk(mclk),
    .rst(rst),
    .time_base(time_base),
    .bit_select({wdog_period_extension, wdog_period}),
    .rise(wd_tick)
  ); // [R12]

  // Fixed-interval period select
  tsf_edge #(.TB_W(TB_W)) u_fit_edge (
    .mclk(mclk),
    .rst(rst),
    .time_base(time_base),
    .bit_select({interval_period_extension, interval_period_select}),
    .rise(fit_tick)
  ); // [R14]

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  tsf_status_s stat_ff;
  tsf_status_s nxt_stat;
  tsf_wd_e wd_ff;
  tsf_wd_e nxt_wd;
  logic exc_ff;
  logic nxt_exc;
  logic [`TSF_REG_W-1:0] clr_mask;

  // Write value is only a clear mask
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction : w1c

  // Flag updates; a set in the same cycle beats the clear
  always_comb begin
    clr_mask = status_wr ? status_wdata : '0; // [R9]
    nxt_stat = stat_ff;
    nxt_wd = wd_ff;
    nxt_exc = 1'b0;
    nxt_stat.next_timeout_arm = w1c(stat_ff.next_timeout_arm, 1'b0,
                                    clr_mask[`TSF_ARM_BIT]); // [R1]
    nxt_stat.wdog_intr_status = w1c(stat_ff.wdog_intr_status, 1'b0,
                                    clr_mask[`TSF_WIS_BIT]); // [R1]
    nxt_stat.wdog_reset_status[1] = stat_ff.wdog_reset_status[1] & ~clr_mask[`TSF_WRS_HI];
    nxt_stat.wdog_reset_status[0] = stat_ff.wdog_reset_status[0] & ~clr_mask[`TSF_WRS_LO];
    nxt_stat.dec_event_flag = w1c(stat_ff.dec_event_flag, dec_zero_event,
                                  clr_mask[`TSF_DEC_BIT]); // [R7] [R1]
    nxt_stat.fixed_interval_flag = w1c(stat_ff.fixed_interval_flag, fit_tick,
                                       clr_mask[`TSF_FIT_BIT]); // [R8] [R1]
    if (wd_tick) begin
      if (!stat_ff.next_timeout_arm) begin
        nxt_stat.next_timeout_arm = 1'b1; // [R3]
      end else if (!stat_ff.wdog_intr_status) begin
        nxt_stat.wdog_intr_status = 1'b1; // [R2]
        nxt_exc = 1'b1; // [R2]
      end else begin
        // Second time-out [R4]
        nxt_stat.wdog_reset_status = wdog_reset_control; // [R15] [R6]
        case (wdog_reset_control)
          `TSF_RC_CHECKSTOP: nxt_wd = TSF_WD_CHECKSTOP; // [R13]
          `TSF_RC_RESET: nxt_wd = TSF_WD_RESET; // [R13]
          default: nxt_wd = wd_ff;
        endcase
      end
    end
  end

  // Flag registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_ff <= '0;
      wd_ff <= TSF_WD_IDLE;
      exc_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      wd_ff <= nxt_wd;
      exc_ff <= nxt_exc;
    end
  end

  // --------------------------------------------------------------------
  // Read data and interrupt requests
  // --------------------------------------------------------------------
  logic [`TSF_REG_W-1:0] rdata_ff;
  logic [`TSF_REG_W-1:0] nxt_rdata;
  logic nxt_wd_req;
  logic nxt_dec_req;
  logic nxt_fit_req;

  // Registered read image; reserved bits zero
  always_comb begin
    nxt_rdata = '0; // [R11] [R16]
    if (status_rd) begin
      nxt_rdata[`TSF_ARM_BIT] = stat_ff.next_timeout_arm; // [R9]
      nxt_rdata[`TSF_WIS_BIT] = stat_ff.wdog_intr_status;
      nxt_rdata[`TSF_WRS_HI:`TSF_WRS_LO] = stat_ff.wdog_reset_status; // [R6]
      nxt_rdata[`TSF_DEC_BIT] = stat_ff.dec_event_flag;
      nxt_rdata[`TSF_FIT_BIT] = stat_ff.fixed_interval_flag;
    end
    nxt_wd_req = stat_ff.wdog_intr_status & gates.wdog_intr_enable
                 & gates.crit_intr_gate; // [R5]
    nxt_dec_req = stat_ff.dec_event_flag & gates.dec_intr_enable
                  & gates.ext_intr_gate; // [R7]
    nxt_fit_req = stat_ff.fixed_interval_flag & gates.fixed_interval_intr_enable
                  & gates.ext_intr_gate; // [R8]
  end

  // Output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= '0;
      wdog_intr_req <= 1'b0;
      dec_intr_req <= 1'b0;
      fixed_interval_intr_req <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      wdog_intr_req <= nxt_wd_req;
      dec_intr_req <= nxt_dec_req;
      fixed_interval_intr_req <= nxt_fit_req;
    end
  end

  // Registered outputs
  always_comb begin
    status_rdata = rdata_ff;
    wdog_exception = exc_ff;
    checkstop = (wd_ff == TSF_WD_CHECKSTOP); // [R13]
    reset_out_n = (wd_ff != TSF_WD_RESET); // [R13]
  end
endmodule : tsf_status
`default_nettype wire

// ==== bench/tsf_status_monitor.sv ====
/*
  Port checker for the timer event status block.
  Assumes a bind onto tsf_status, one clock, synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module tsf_status_monitor
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire logic [1:0] wdog_reset_control,
  input wire tsf_gate_s gates,
  input wire logic status_rd,
  input wire logic [31:0] status_rdata,
  input wire logic wdog_intr_req,
  input wire logic dec_intr_req,
  input wire logic fixed_interval_intr_req,
  input wire logic wdog_exception,
  input wire logic checkstop,
  input wire logic reset_out_n
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rsvd_read_zero: assert property (status_rdata[25:0] == 26'h0)
    else $error("reserved bits read nonzero");
  a_rdata_idle_zero: assert property (!$past(status_rd) |-> status_rdata == 32'h0)
    else $error("read data without a read");
  a_wdog_req_gated: assert property (wdog_intr_req |->
    $past(gates.wdog_intr_enable && gates.crit_intr_gate))
    else $error("watchdog request without gates");
  a_dec_req_gated: assert property (dec_intr_req |->
    $past(gates.dec_intr_enable && gates.ext_intr_gate))
    else $error("decrementer request without gates");
  a_fit_req_gated: assert property (fixed_interval_intr_req |->
    $past(gates.fixed_interval_intr_enable && gates.ext_intr_gate))
    else $error("interval request without gates");
  a_exc_one_cycle: assert property (wdog_exception |=> !wdog_exception)
    else $error("exception longer than one cycle");
  a_exc_then_req: assert property (wdog_exception && gates.wdog_intr_enable
    && gates.crit_intr_gate |=> wdog_intr_req)
    else $error("exception not followed by request");
  a_stop_sticky: assert property (checkstop |=> checkstop)
    else $error("checkstop dropped");
  a_rout_sticky: assert property (!reset_out_n |=> !reset_out_n)
    else $error("reset output released");
  a_stop_cause: assert property ($rose(checkstop) |-> $past(wdog_reset_control) == 2'h1)
    else $error("checkstop with wrong control");
  a_rout_cause: assert property ($fell(reset_out_n) |-> $past(wdog_reset_control) == 2'h2)
    else $error("reset output with wrong control");
endmodule : tsf_status_monitor
bind tsf_status tsf_status_monitor u_mon (.mclk, .rst, .wdog_reset_control, .gates,
  .status_rd, .status_rdata, .wdog_intr_req, .dec_intr_req, .fixed_interval_intr_req,
  .wdog_exception, .checkstop, .reset_out_n);
`default_nettype wire

// ==== bench/tsf_core_sw.sv ====
/*
  Core software model: whole-word reads and clear-mask writes.
  Assumes tasks are called from the bench; drives at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module tsf_core_sw (
  // Clock
  input wire logic mclk,
  // Register access
  output logic status_rd,
  output logic status_wr,
  output logic [31:0] status_wdata
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial begin
    status_rd = 1'b0;
    status_wr = 1'b0;
    status_wdata = 32'h0;
  end
  // One-cycle read strobe
  task automatic rd_req();
    @(negedge mclk);
    status_rd = 1'b1;
    @(negedge mclk);
    status_rd = 1'b0;
  endtask : rd_req
  // Clear mask, reserved positions always zero
  task automatic wr_mask(input logic [31:0] m);
    @(negedge mclk);
    status_wr = 1'b1;
    status_wdata = m & 32'hfc00_0000;
    @(negedge mclk);
    status_wr = 1'b0;
    status_wdata = ~status_wdata; // Inverted mask left on the bus
  endtask : wr_mask
endmodule : tsf_core_sw
`default_nettype wire

// ==== bench/tb_tsf_status.sv ====
/*
  Self-checking bench for tsf_status.
  Assumes the monitor is bound in and tsf_core_sw drives the register side.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_tsf_status
  import tsf_pkg::*;
;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  logic mclk, rst, rd_d, status_rd, status_wr, cs, rn;
  logic wreq, dreq, freq, wexc, stop, rout_n;
  logic [64:0] src;
  logic [31:0] wdata, rdata;
  logic [1:0] rc;
  logic [15:0] r;
  logic [36:0] q[$];
  tsf_gate_s g;
  tsf_status_s ex;
  int fails, n_tests;
  int n_exc = 0;
  tsf_core_sw sw (.mclk(mclk), .status_rd(status_rd), .status_wr(status_wr),
    .status_wdata(wdata));
  tsf_status DUT (.mclk(mclk), .rst(rst), .time_base(src[63:0]), .dec_zero_event(src[64]),
    .wdog_period(2'h0), .wdog_period_extension(4'h0), .interval_period_select(2'h3),
    .interval_period_extension(4'hf), .wdog_reset_control(rc), .gates(g),
    .status_rd(status_rd), .status_wr(status_wr), .status_wdata(wdata),
    .status_rdata(rdata), .wdog_intr_req(wreq), .dec_intr_req(dreq),
    .fixed_interval_intr_req(freq), .wdog_exception(wexc), .checkstop(stop),
    .reset_out_n(rout_n));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // One pulse on a source bit: 0..63 time base, 64 decrementer event
  task automatic bump(input int b);
    @(negedge mclk);
    src[b] = 1'b1;
    @(negedge mclk);
    src[b] = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : bump
  // Note the expected word, then read
  task automatic chk();
    q.push_back({ex, 26'h0, ex.wdog_intr_status & g.wdog_intr_enable & g.crit_intr_gate,
      ex.dec_event_flag & g.dec_intr_enable & g.ext_intr_gate,
      ex.fixed_interval_flag & g.fixed_interval_intr_enable & g.ext_intr_gate, cs, rn});
    sw.rd_req();
  endtask : chk
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Read results compared against the oldest note
  always @(posedge mclk) rd_d <= status_rd;
  // Exception pulses counted where settled
  always @(negedge mclk) if (wexc === 1'b1) n_exc++;
  always @(negedge mclk) begin
    if (rd_d) begin
      n_tests++;
      if ({rdata, wreq, dreq, freq, stop, rout_n} !== q.pop_front()) begin
        fails++;
        $display("CHECK FAILED %0t status or request mismatch", $time);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst, src, rc, g, ex, cs, rn, fails, n_tests} = {1'b1, 65'h0, 2'h0, 5'h1f, 6'h0, 2'h1, 64'h0};
    r = 16'h4ceb;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk();
    g.ext_intr_gate = 1'b0;
    bump(64);
    ex.dec_event_flag = 1'b1;
    chk();
    g.ext_intr_gate = 1'b1;
    chk();
    bump(0); // Select 63 is time base bit 0
    ex.fixed_interval_flag = 1'b1;
    chk();
    g.fixed_interval_intr_enable = 1'b0;
    chk();
    g.fixed_interval_intr_enable = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      bump(64);
      bump(0);
      ex = ex | 6'h3;
      sw.wr_mask({r, r});
      ex = ex & ~tsf_status_s'(r[15:10]);
      chk();
    end
    for (int k = 0; k < 4; k++) begin
      rst = 1'b1;
      rc = k[1:0];
      {ex, cs, rn} = {6'h0, 2'h1};
      @(negedge mclk);
      rst = 1'b0;
      bump(63); // Select 0 is time base bit 63
      ex.next_timeout_arm = 1'b1;
      chk();
      bump(63);
      ex.wdog_intr_status = 1'b1;
      chk();
      n_tests++;
      if (n_exc != k + 1) begin
        fails++;
        $display("CHECK FAILED %0t exception count mismatch", $time);
      end
      g.crit_intr_gate = 1'b0;
      chk();
      g.crit_intr_gate = 1'b1;
      bump(63);
      ex.wdog_reset_status = rc;
      {cs, rn} = {rc == 2'h1, rc != 2'h2};
      chk();
      sw.wr_mask(32'h4000_0000);
      ex.wdog_intr_status = 1'b0;
      chk();
    end
    repeat (2) @(negedge mclk);
    tally_and_finish();
  end
endmodule : tb_tsf_status
`default_nettype wire
